/* logic/pltc_pkg.sv */
// Constants and state type for the physical-layer loopback and test control block.
`default_nettype none
package pltc_pkg;
    // Register offsets within the station's configuration space.
    localparam logic [11:0] PLTC_TEST_OFS = 12'h228;
    localparam logic [11:0] PLTC_PORT_OFS = 12'h230;
    // Field positions in the test control register.
    localparam int PLTC_SKIP_BIT = 4;
    localparam int PLTC_PRBS_LSB = 16;
    localparam int PLTC_SER_LSB = 20;
    localparam int PLTC_PAR_LSB = 24;
    localparam int PLTC_PATTERN_LSB = 28;
    // Quad and port counts per station, and the width of one port slot.
    localparam int PLTC_QUADS = 4;
    localparam int PLTC_PORTS = 3;
    localparam int PLTC_SLOT_W = 4;
    // Bit positions inside one port slot of the port command register.
    localparam int PLTC_CMD_LB = 0;
    localparam int PLTC_CMD_SCR = 1;
    localparam int PLTC_CMD_CRX = 2;
    localparam int PLTC_CMD_RDY = 3;
    // Writable bits of the test register, and the quad 2/3 bits held reserved in station 0.
    localparam logic [31:0] PLTC_TEST_WMASK = 32'hffff_0010;
    localparam logic [31:0] PLTC_TEST_RSVD_ST0 = 32'hcccc_0000;
    // Writable bits of one port slot; the ready bit is read only.
    localparam logic [3:0] PLTC_SLOT_WMASK = 4'h7;
    // Port slots that carry a real port, per station.
    localparam logic [2:0] PLTC_SLOTS_ST0 = 3'h3;
    localparam logic [2:0] PLTC_SLOTS_ST1 = 3'h6;
    localparam logic [2:0] PLTC_SLOTS_ST2 = 3'h3;
    // Symbol times between SKIP ordered sets in skip timer test mode.
    localparam int PLTC_SKIP_TEST_SYMBOLS = 256;
    // Width of the stored port command field.
    localparam int PLTC_CMD_W = 12;
    // Source of a register write.
    typedef enum logic [0:0] {
        PLTC_SRC_SW = 1'b0,
        PLTC_SRC_SERIAL = 1'b1
    } pltc_src_t;
    // All state of the block.
    typedef struct packed {
        logic [31:0] test;
        logic [PLTC_CMD_W-1:0] cmd;
        logic [PLTC_PORTS-1:0] pend;
        logic [PLTC_PORTS-1:0] path;
        logic [31:0] rdata;
    } pltc_state_t;
endpackage
`default_nettype wire

/* logic/pltc_top.sv */
// Physical-layer loopback, test pattern and scrambler control for one switch station.
`default_nettype none
module pltc_top #(
    parameter int STATION = 0
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic reg_wr_en_in,
    input wire logic reg_rd_en_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_src_in,
    input wire logic [2:0] cfg_reached_in,
    input wire logic [2:0] cfg_complete_in,
    input wire logic [2:0] lpbk_master_active_in,
    output logic [31:0] reg_rdata_out,
    output logic [3:0] serial_lpbk_out,
    output logic [3:0] parallel_lpbk_out,
    output logic par_tap_pre_ebuf_out,
    output logic [3:0] user_pattern_gen_out,
    output logic [3:0] prbs7_en_out,
    output logic skip_test_out,
    output logic [2:0] lpbk_master_req_out,
    output logic [2:0] lpbk_via_recovery_out,
    output logic [2:0] scram_dis_out,
    output logic [2:0] dis_scram_training_control_bit_out,
    output logic [2:0] compliance_rx_training_control_bit_out
);
    // Current and next state of the whole block.
    pltc_pkg::pltc_state_t q, d;
    // Writable masks and live port slots for this station.
    logic [31:0] test_wmask;
    logic [2:0] slot_live;

    // Station-dependent masks: factory bits never take a write from any source.
    always_comb begin
        test_wmask = pltc_pkg::PLTC_TEST_WMASK;
        slot_live = pltc_pkg::PLTC_SLOTS_ST0;
        if (STATION == 0) begin
            test_wmask = pltc_pkg::PLTC_TEST_WMASK & ~pltc_pkg::PLTC_TEST_RSVD_ST0;
        end
        if (STATION == 1) begin
            slot_live = pltc_pkg::PLTC_SLOTS_ST1;
        end else if (STATION == 2) begin
            slot_live = pltc_pkg::PLTC_SLOTS_ST2;
        end
    end

    // Next-state logic for registers, per-port tracking and read data.
    always_comb begin
        logic [3:0] nib;
        logic [3:0] old;
        nib = 4'h0;
        old = 4'h0;
        d = q;
        // Test register write: masked merge keeps reserved bits at zero.
        if (reg_wr_en_in && reg_addr_in == pltc_pkg::PLTC_TEST_OFS) begin
            d.test = (reg_wdata_in & test_wmask) | (q.test & ~test_wmask);
        end
        for (int i = 0; i < pltc_pkg::PLTC_PORTS; i++) begin
            old = q.cmd[i*pltc_pkg::PLTC_SLOT_W +: pltc_pkg::PLTC_SLOT_W];
            // Serial-load disable takes effect once training completes.
            if (cfg_complete_in[i]) begin
                d.pend[i] = 1'b0;
            end
            if (reg_wr_en_in && reg_addr_in == pltc_pkg::PLTC_PORT_OFS && slot_live[i]) begin
                nib = reg_wdata_in[i*pltc_pkg::PLTC_SLOT_W +: pltc_pkg::PLTC_SLOT_W];
                d.cmd[i*pltc_pkg::PLTC_SLOT_W +: 3] = nib[2:0] & pltc_pkg::PLTC_SLOT_WMASK[2:0];
                // A fresh command records which training state leads to loopback.
                if (nib[pltc_pkg::PLTC_CMD_LB] && !old[pltc_pkg::PLTC_CMD_LB]) begin
                    d.path[i] = cfg_reached_in[i];
                end
                // A cleared bit or any software write ends a wait; a fresh serial load starts one.
                if (!nib[pltc_pkg::PLTC_CMD_SCR] || reg_src_in == pltc_pkg::PLTC_SRC_SW) begin
                    d.pend[i] = 1'b0;
                end else if (!old[pltc_pkg::PLTC_CMD_SCR]) begin
                    d.pend[i] = 1'b1;
                end
            end
            // Ready tracks Loopback.Active as master while the command stands.
            d.cmd[i*pltc_pkg::PLTC_SLOT_W + pltc_pkg::PLTC_CMD_RDY] =
                slot_live[i] & lpbk_master_active_in[i] & old[pltc_pkg::PLTC_CMD_LB];
        end
        // Registered read; unmapped offsets read zero.
        if (reg_rd_en_in) begin
            if (reg_addr_in == pltc_pkg::PLTC_TEST_OFS) begin
                d.rdata = q.test;
            end else if (reg_addr_in == pltc_pkg::PLTC_PORT_OFS) begin
                d.rdata = {20'h0_0000, q.cmd};
            end else begin
                d.rdata = 32'h0000_0000;
            end
        end
    end

    // State register; reset restores normal link operation.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Quad controls drive the SerDes lane groups straight from the register.
    assign serial_lpbk_out = q.test[pltc_pkg::PLTC_SER_LSB +: pltc_pkg::PLTC_QUADS];
    assign parallel_lpbk_out = q.test[pltc_pkg::PLTC_PAR_LSB +: pltc_pkg::PLTC_QUADS];
    assign par_tap_pre_ebuf_out = q.test[pltc_pkg::PLTC_SKIP_BIT];
    assign skip_test_out = q.test[pltc_pkg::PLTC_SKIP_BIT];
    assign user_pattern_gen_out = q.test[pltc_pkg::PLTC_PATTERN_LSB +: pltc_pkg::PLTC_QUADS];
    assign prbs7_en_out = q.test[pltc_pkg::PLTC_PRBS_LSB +: pltc_pkg::PLTC_QUADS];
    assign reg_rdata_out = q.rdata;

    // Per-port command outputs, one slot each.
    genvar g;
    generate
        for (g = 0; g < pltc_pkg::PLTC_PORTS; g++) begin : g_port
            assign lpbk_master_req_out[g] =
                q.cmd[g*pltc_pkg::PLTC_SLOT_W + pltc_pkg::PLTC_CMD_LB];
            assign lpbk_via_recovery_out[g] = q.path[g];
            assign scram_dis_out[g] =
                q.cmd[g*pltc_pkg::PLTC_SLOT_W + pltc_pkg::PLTC_CMD_SCR] & ~q.pend[g];
            assign dis_scram_training_control_bit_out[g] =
                q.cmd[g*pltc_pkg::PLTC_SLOT_W + pltc_pkg::PLTC_CMD_SCR];
            assign compliance_rx_training_control_bit_out[g] =
                q.cmd[g*pltc_pkg::PLTC_SLOT_W + pltc_pkg::PLTC_CMD_CRX];
        end
    endgenerate

    // Checks on the register-to-output relations.
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    logic wr_test;
    logic wr_port;
    assign wr_test = reg_wr_en_in && reg_addr_in == pltc_pkg::PLTC_TEST_OFS;
    assign wr_port = reg_wr_en_in && reg_addr_in == pltc_pkg::PLTC_PORT_OFS;

    property p_ser;
        wr_test |=> serial_lpbk_out == ($past(reg_wdata_in[23:20]) & $past(test_wmask[23:20]));
    endproperty
    a_ser: assert property (p_ser) else $error("serial loopback mismatch");
    property p_par;
        wr_test |=> parallel_lpbk_out == ($past(reg_wdata_in[27:24]) & $past(test_wmask[27:24]));
    endproperty
    a_par: assert property (p_par) else $error("parallel loopback mismatch");
    property p_tap;
        wr_test |=> par_tap_pre_ebuf_out == $past(reg_wdata_in[4]);
    endproperty
    a_tap: assert property (p_tap) else $error("loopback tap mismatch");
    property p_pattern;
        wr_test |=> user_pattern_gen_out == ($past(reg_wdata_in[31:28]) & $past(test_wmask[31:28]));
    endproperty
    a_pattern: assert property (p_pattern) else $error("user pattern mismatch");
    // Pseudo-random enables follow the written bits, reserved quads masked.
    property p_prbs;
        wr_test |=> prbs7_en_out == ($past(reg_wdata_in[19:16]) & $past(test_wmask[19:16]));
    endproperty
    a_prbs: assert property (p_prbs) else $error("pseudo-random enable mismatch");
    property p_st0_rsvd;
        (STATION == 0) |-> (serial_lpbk_out[3:2] == 2'b00 && user_pattern_gen_out[3:2] == 2'b00);
    endproperty
    a_st0_rsvd: assert property (p_st0_rsvd) else $error("reserved quad bit set");
    property p_lb_req;
        wr_port |=> lpbk_master_req_out[1] == $past(reg_wdata_in[4] & slot_live[1]);
    endproperty
    a_lb_req: assert property (p_lb_req) else $error("loopback request mismatch");
    property p_crx;
        wr_port |=> compliance_rx_training_control_bit_out[0] == $past(reg_wdata_in[2] & slot_live[0]);
    endproperty
    a_crx: assert property (p_crx) else $error("compliance training bit mismatch");
    property p_sw_scr;
        (wr_port && slot_live[0] && reg_wdata_in[1] && reg_src_in == pltc_pkg::PLTC_SRC_SW)
            |=> scram_dis_out[0] && dis_scram_training_control_bit_out[0];
    endproperty
    a_sw_scr: assert property (p_sw_scr) else $error("software disable not immediate");
    property p_ser_scr;
        (wr_port && slot_live[0] && reg_wdata_in[1] && !q.cmd[1] && !cfg_complete_in[0]
            && reg_src_in == pltc_pkg::PLTC_SRC_SERIAL) |=> !scram_dis_out[0];
    endproperty
    a_ser_scr: assert property (p_ser_scr) else $error("serial disable acted early");
    // Once loopback master is reported with the command set, a read shows the ready bit.
    property p_ready;
        (lpbk_master_active_in[0] && lpbk_master_req_out[0] && slot_live[0])
            ##1 (reg_rd_en_in && reg_addr_in == pltc_pkg::PLTC_PORT_OFS) |=> reg_rdata_out[3];
    endproperty
    a_ready: assert property (p_ready) else $error("ready bit not set");
    property p_ready_clr;
        !lpbk_master_active_in[0] |=> !q.cmd[3];
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("ready bit not cleared");
    // A dead port slot never takes a command from any write.
    property p_dead_slot;
        !slot_live[2] |-> (lpbk_master_req_out[2] == 1'b0 && scram_dis_out[2] == 1'b0);
    endproperty
    a_dead_slot: assert property (p_dead_slot) else $error("dead port slot written");

    // Main scenarios: loopback request, pattern on, ready seen, serial load released.
    c_lb: cover property (wr_port ##1 lpbk_master_req_out != 3'h0);
    c_pattern: cover property (user_pattern_gen_out != 4'h0);
    c_ready: cover property (q.cmd[3] || q.cmd[7]);
    c_pend: cover property (q.pend[0] ##1 cfg_complete_in[0]);
endmodule
`default_nettype wire

/* testbench/pltc_ltssm_model.sv */
// Link training stand-in that answers the loopback command of each port slot.
`default_nettype none
module pltc_ltssm_model #(
    parameter int SLOW = 0
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [2:0] lpbk_req_in,
    input wire logic [2:0] link_up_in,
    input wire logic [2:0] cfg_done_in,
    output logic [2:0] cfg_reached_out,
    output logic [2:0] cfg_complete_out,
    output logic [2:0] lpbk_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] stage_q; // Command as seen one cycle ago.
    // Training levels follow the bench; loopback follows the command, one or two cycles late.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            stage_q <= 3'h0;
            cfg_reached_out <= 3'h0;
            cfg_complete_out <= 3'h0;
            lpbk_active_out <= 3'h0;
        end else begin
            stage_q <= lpbk_req_in;
            cfg_reached_out <= link_up_in;
            cfg_complete_out <= cfg_done_in;
            // Loopback is held only while the command stays set.
            lpbk_active_out <= ((SLOW != 0) ? stage_q : lpbk_req_in) & lpbk_req_in;
        end
    end
endmodule
`default_nettype wire

/* testbench/phy_loopback_test_control_tb.sv */
// Self-checking bench for the loopback and test control block of station 0.
`default_nettype none
module phy_loopback_test_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic src = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [2:0] link_up = 3'h0;
    logic [2:0] cfg_done = 3'h0;
    logic [2:0] reached, complete, active, req, via, sdis, stcb, crx;
    logic [31:0] rdata, exp_test, v, got;
    logic [3:0] ser, par, pat, prbs;
    // Behavioural model: register contents, expected ready bits and pending read results.
    logic [31:0] mdl_test = 32'h0000_0000;
    logic [31:0] mdl_cmd = 32'h0000_0000;
    logic [31:0] mdl_rdy = 32'h0000_0000;
    logic [31:0] rd_q[$];
    // Writable bits of each register in station 0: live quads, skip bit, live port slots.
    localparam logic [31:0] TEST_MASK = pltc_pkg::PLTC_TEST_WMASK & ~pltc_pkg::PLTC_TEST_RSVD_ST0;
    localparam logic [31:0] CMD_MASK = 32'h0000_0077;
    logic tap, skip;
    int miscompares = 0;
    int samples_checked = 0;
    // Free-running clock of 8 ns.
    always #4 mclk_in = ~mclk_in;
    pltc_top #(.STATION(0)) pltc_top_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_src_in(src), .cfg_reached_in(reached), .cfg_complete_in(complete),
        .lpbk_master_active_in(active), .reg_rdata_out(rdata), .serial_lpbk_out(ser),
        .parallel_lpbk_out(par), .par_tap_pre_ebuf_out(tap), .user_pattern_gen_out(pat),
        .prbs7_en_out(prbs), .skip_test_out(skip), .lpbk_master_req_out(req),
        .lpbk_via_recovery_out(via), .scram_dis_out(sdis),
        .dis_scram_training_control_bit_out(stcb),
        .compliance_rx_training_control_bit_out(crx));
    pltc_ltssm_model #(.SLOW(1)) pltc_ltssm_model_inst (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .lpbk_req_in(req), .link_up_in(link_up),
        .cfg_done_in(cfg_done), .cfg_reached_out(reached), .cfg_complete_out(complete),
        .lpbk_active_out(active));
    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d.", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Compares one value with its expectation and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Applies one register write to the model; reserved and read-only bits stay zero.
    function automatic void mdl_write(input logic [11:0] a, input logic [31:0] d);
        if (a == pltc_pkg::PLTC_TEST_OFS) begin
            mdl_test = d & TEST_MASK;
        end else if (a == pltc_pkg::PLTC_PORT_OFS) begin
            mdl_cmd = d & CMD_MASK;
        end
    endfunction
    // Returns what the model expects a read of the given offset to give.
    function automatic logic [31:0] mdl_read(input logic [11:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == pltc_pkg::PLTC_TEST_OFS) begin
            r = mdl_test;
        end else if (a == pltc_pkg::PLTC_PORT_OFS) begin
            r = mdl_cmd | mdl_rdy;
        end
        return r;
    endfunction
    // One write strobe, then one settling cycle before outputs are looked at.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic s);
        @(posedge mclk_in);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        src <= s;
        @(posedge mclk_in);
        wr_en <= 1'b0;
        mdl_write(a, d);
        @(posedge mclk_in);
        #1;
    endtask
    // One read strobe; the model's answer is queued and checked once the next edge has landed.
    task automatic rd(input logic [11:0] a);
        @(posedge mclk_in);
        rd_en <= 1'b1;
        addr <= a;
        rd_q.push_back(mdl_read(a));
        @(posedge mclk_in);
        rd_en <= 1'b0;
        #1;
        chk(rdata, rd_q.pop_front());
    endtask
    // Bounded wait for the partner to report loopback on the given slots.
    task automatic wait_active(input logic [2:0] want);
        int n;
        n = 0;
        while (active !== want && n < 20) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        if (active !== want) begin
            miscompares++;
            $display("Error at %0t: loopback not reached", $time);
            end_of_test();
        end
    endtask
    // Main sequence: reset, loopback entry, test register under loopback, scrambler, reset.
    initial begin
        void'($urandom(37));
        repeat (6) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rd(pltc_pkg::PLTC_TEST_OFS);
        rd(pltc_pkg::PLTC_PORT_OFS);
        rd(12'h22c);
        // Slot 1 has reached Configuration, slot 0 has not; both take the loopback command.
        @(posedge mclk_in);
        link_up <= 3'h2;
        v = ($urandom & 32'h0000_0066) | 32'hffff_ff11;
        wr(pltc_pkg::PLTC_PORT_OFS, v, 1'b0);
        wait_active(3'h3);
        mdl_rdy = (mdl_cmd & 32'h0000_0011) << 3;
        repeat (2) @(posedge mclk_in);
        rd(pltc_pkg::PLTC_PORT_OFS);
        exp_test = {17'h0, 1'b0, v[4], v[0], 3'h2, 1'b0, v[5], v[1], 1'b0, v[5], v[1],
            1'b0, v[6], v[2]};
        got = {17'h0, req, via, sdis, stcb, crx};
        chk(got, exp_test);
        // The user pattern is only turned on while both live ports are loopback masters.
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 32'hffff_ffff : $urandom;
            v[19:16] = v[19:16] & ~v[31:28];
            wr(pltc_pkg::PLTC_TEST_OFS, v, k[0]);
            rd(pltc_pkg::PLTC_TEST_OFS);
            exp_test = {mdl_test[31:16], 14'h0, mdl_test[4], mdl_test[4]};
            got = {pat, par, ser, prbs, 14'h0, skip, tap};
            chk(got, exp_test);
        end
        // Pattern off again before the ports leave loopback.
        wr(pltc_pkg::PLTC_TEST_OFS, 32'h0000_0000, 1'b0);
        chk({16'h0, pat, par, ser, prbs}, 32'h0000_0000);
        wr(pltc_pkg::PLTC_PORT_OFS, 32'h0000_0000, 1'b0);
        mdl_rdy = 32'h0000_0000;
        repeat (3) @(posedge mclk_in);
        #1;
        chk({29'h0, req}, 32'h0000_0000);
        rd(pltc_pkg::PLTC_PORT_OFS);
        // A serial load waits for Configuration.Complete before the scrambler stops.
        wr(pltc_pkg::PLTC_PORT_OFS, 32'h0000_0002, 1'b1);
        repeat (3) @(posedge mclk_in);
        #1;
        chk({26'h0, stcb, sdis}, {26'h0, 3'h1, 3'h0});
        @(posedge mclk_in);
        cfg_done <= 3'h1;
        repeat (4) @(posedge mclk_in);
        #1;
        chk({29'h0, sdis}, 32'h0000_0001);
        // A software write of the bit stops the scrambler at once, even over a waiting load.
        @(posedge mclk_in);
        cfg_done <= 3'h0;
        wr(pltc_pkg::PLTC_PORT_OFS, 32'h0000_0000, 1'b0);
        wr(pltc_pkg::PLTC_PORT_OFS, 32'h0000_0002, 1'b1);
        chk({29'h0, sdis}, 32'h0000_0000);
        wr(pltc_pkg::PLTC_PORT_OFS, 32'h0000_0002, 1'b0);
        chk({29'h0, sdis}, 32'h0000_0001);
        // A reset in mid-run returns every control to normal link operation.
        wr(pltc_pkg::PLTC_TEST_OFS, 32'h0fff_ffff, 1'b0);
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        mdl_test = 32'h0000_0000;
        mdl_cmd = 32'h0000_0000;
        #1;
        chk({16'h0, pat, par, ser, prbs}, 32'h0000_0000);
        chk({15'h0, req, via, sdis, stcb, crx, skip, tap}, 32'h0000_0000);
        rd(pltc_pkg::PLTC_TEST_OFS);
        rd(pltc_pkg::PLTC_PORT_OFS);
        end_of_test();
    end
endmodule
`default_nettype wire
